// ===== sim/rcflag_chk.sv
// Flag register assertions
`timescale 1ns/1ps
`default_nettype none
module rcflag_chk (input wire logic clk, input wire logic rst_n, input wire logic [7:0] flags,
   input wire rcflag_pkg::rcflag_events_t events, input wire logic externalResetPin);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_POR: assert property ($rose(rst_n) |-> flags == 8'h3C) else $error("por");
   AST_OVF: assert property (events[6] |=> flags[7]) else $error("ovf");
   AST_UNF: assert property (events[5] |=> flags[6]) else $error("unf");
   AST_WV: assert property (events[4] |=> !flags[5]) else $error("wv");
   AST_WT: assert property (events[3] |=> !flags[4]) else $error("wt");
   sequence sqPinRise;
      $rose(externalResetPin);
   endsequence
   sequence sqPinFlagLow;
      ##[1:4] !flags[3];
   endsequence
   AST_XR: assert property (sqPinRise |-> sqPinFlagLow)
      else $error("pin");
   AST_RI: assert property (events[1] |=> !flags[2]) else $error("ri");
   AST_BOR: assert property (events[0] |=> !flags[0]) else $error("bor");
endmodule
bind rcflag_reset_cause_flag_register rcflag_chk CHK (.clk, .rst_n, .flags, .events,
   .externalResetPin);
`default_nettype wire

// ===== sim/rcflag_src.sv
// Model of the on-chip reset sources
`timescale 1ns/1ps
`default_nettype none
module rcflag_src (
   // Source request, one bit per cause
   input wire logic [7:0] req,
   // Strobes and pin level to the register
   output rcflag_pkg::rcflag_events_t events,
   output logic pin
);
   assign {pin, events} = req;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Bench for the flag register
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin comparisons++; if ((g)!==(e)) begin failCount++; \
   $display("CHECK FAILED %s %h %h", n, e, g); end end
module tb;
   logic clk = 1'h0, rst_n = 1'h0, wrEn = 1'h0, rdEn = 1'h0, externalResetPin;
   logic [3:0] addr = 4'h0;
   logic [7:0] wrData = 8'h00, req = 8'h00, flags, rdData, d;
   rcflag_pkg::rcflag_events_t events;
   int failCount = 0, comparisons = 0, seed = 87;
   rcflag_src SRC (.req, .events, .pin(externalResetPin));
   rcflag_reset_cause_flag_register DUT (.clk(clk), .rst_n(rst_n), .events(events),
      .externalResetPin(externalResetPin), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .flags(flags));
   initial forever #5 clk = ~clk;
   initial #9000 stopTest(1);
   task automatic stopTest(int bad);
      failCount += bad;
      $display("checks %0d failed %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic op(logic w, logic [3:0] a, logic [7:0] v);
      @(posedge clk);
      {wrEn, rdEn, addr, wrData} <= {w, !w, a, v};
      @(posedge clk);
      {wrEn, rdEn} <= 2'h0;
   endtask
   // Flag image after source s fires on value v
   function automatic logic [7:0] ev(logic [7:0] v, int s);
      ev = v;
      ev[s == 0 ? 0 : s == 7 ? 3 : s + 1] = s inside {5, 6};
   endfunction
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      `CHK("por", rcflag_pkg::FLAGS_POR_VAL, flags)
      op(1'h1, 4'h0, 8'h3F);
      #1;
      `CHK("fwset", 8'h3F, flags)
      $display("power-on done");
      for (int i = 0; i < 8; i++) begin
         d = ~ev(8'($random(seed)), i);
         op(1'h1, 4'h0, d);
         req <= 8'(8'h01 << i);
         @(posedge clk);
         req <= 8'h00;
         repeat (4) @(posedge clk);
         op(1'h0, 4'h0, 8'h00);
         #1;
         `CHK("flags", ev(d, i), rdData)
      end
      $display("sources done");
      op(1'h1, 4'h9, 8'h5A);
      op(1'h0, 4'h9, 8'h00);
      #1;
      `CHK("unmapped", 8'h00, rdData)
      `CHK("kept", ev(d, 7), flags)
      $display("port done");
      rst_n <= 1'h0;
      @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      `CHK("rerun", rcflag_pkg::FLAGS_POR_VAL, flags)
      $display("reset done");
      stopTest(0);
   end
endmodule
`default_nettype wire

// ===== verilog/rcflag_pkg.sv
// Package: reset-cause flag register constants and carrier types
package rcflag_pkg;
   localparam int FLAG_W = 8;
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam int BIT_STACK_OVERFLOW_FLAG_POS = 7;
   localparam int BIT_STACK_UNDERFLOW_FLAG_POS = 6;
   localparam int BIT_WDWV_POS = 5;
   localparam int BIT_WDTO_POS = 4;
   localparam int BIT_EXTPIN_POS = 3;
   localparam int BIT_RSTINS_POS = 2;
   localparam int BIT_POR_POS = 1;
   localparam int BIT_BOR_POS = 0;
   // Value forced at a power-on reset
   localparam logic [7:0] FLAGS_POR_VAL = 8'h3C;
   // Event strobes from on-chip sources
   typedef struct packed {
      logic stackOverflow;
      logic stackUnderflow;
      logic windowViolation;
      logic watchdogTimeout;
      logic externalPinReset;
      logic resetInstruction;
      logic brownoutReset;
   } rcflag_events_t;
endpackage

// ===== verilog/rcflag_reset_cause_flag_register.sv
// Reset-cause flag register with register port and hardware event inputs
// Operation
// R01: Stack overflow sets bit 7, zero at power-on, held until firmware clears it.
// R02: Stack underflow sets bit 6, zero at power-on, cleared only by firmware write.
// R03: A badly timed watchdog clear clears bit 5, which is one at power-on and writable.
// R04: A watchdog timeout reset clears bit 4, which otherwise reads one and is writable.
// R05: An external pin reset clears bit 3, which otherwise reads one and is writable.
// R06: A reset instruction clears bit 2, which otherwise reads one and is writable.
// R07: Power-on reset clears bit 1 and firmware sets it back to one afterwards.
// R08: Brown-out reset clears bit 0 and firmware sets it to one after power-on or brown-out.
// R09: Resets other than power-on leave every flag alone except their own cause flag.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcflag_reset_cause_flag_register (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // Reset and fault event strobes and the external reset pin level
   input wire rcflag_pkg::rcflag_events_t events,
   input wire logic externalResetPin,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [7:0] rdData,
   // Live flag view
   output logic [7:0] flags
);
   logic pinSync;
   logic pinSyncDly;
   logic pinEvent;
   logic flagWrite;
   logic flagRead;
   // One flop per flag, gathered into the register image
   logic stackOverflowFlag;
   logic stackUnderflowFlag;
   logic watchdogWindowViolationFlag;
   logic watchdogTimeoutResetFlagN;
   logic externalResetPinFlagN;
   logic resetInstructionFlagN;
   logic powerOnResetFlagN;
   logic brownoutResetFlagN;

   // Register port address decode
   function automatic logic addrHit(input logic [3:0] a);
      addrHit = (a == rcflag_pkg::ADDR_FLAGS);
   endfunction

   rcflag_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(externalResetPin),
      .syncOut(pinSync)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSyncDly <= 1'b0;
      end else begin
         pinSyncDly <= pinSync;
      end
   end

   // Pin assertion edge, or strobe from reset logic
   assign pinEvent = (pinSync & ~pinSyncDly) | events.externalPinReset;
   assign flagWrite = wrEn && addrHit(addr);
   assign flagRead = rdEn && addrHit(addr);

   // Hardware event wins over a same-cycle firmware write of its bit
   // R09: each flop moves only on its own cause or a write

   // R01: overflow sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stackOverflowFlag <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_STACK_OVERFLOW_FLAG_POS];
      end else if (events.stackOverflow) begin
         stackOverflowFlag <= 1'b1;
      end else if (flagWrite) begin
         stackOverflowFlag <= wrData[rcflag_pkg::BIT_STACK_OVERFLOW_FLAG_POS];
      end
   end

   // R02: underflow sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stackUnderflowFlag <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_STACK_UNDERFLOW_FLAG_POS];
      end else if (events.stackUnderflow) begin
         stackUnderflowFlag <= 1'b1;
      end else if (flagWrite) begin
         stackUnderflowFlag <= wrData[rcflag_pkg::BIT_STACK_UNDERFLOW_FLAG_POS];
      end
   end

   // R03: window violation clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdogWindowViolationFlag <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_WDWV_POS];
      end else if (events.windowViolation) begin
         watchdogWindowViolationFlag <= 1'b0;
      end else if (flagWrite) begin
         watchdogWindowViolationFlag <= wrData[rcflag_pkg::BIT_WDWV_POS];
      end
   end

   // R04: watchdog timeout clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdogTimeoutResetFlagN <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_WDTO_POS];
      end else if (events.watchdogTimeout) begin
         watchdogTimeoutResetFlagN <= 1'b0;
      end else if (flagWrite) begin
         watchdogTimeoutResetFlagN <= wrData[rcflag_pkg::BIT_WDTO_POS];
      end
   end

   // R05: pin reset clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         externalResetPinFlagN <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_EXTPIN_POS];
      end else if (pinEvent) begin
         externalResetPinFlagN <= 1'b0;
      end else if (flagWrite) begin
         externalResetPinFlagN <= wrData[rcflag_pkg::BIT_EXTPIN_POS];
      end
   end

   // R06: instruction clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resetInstructionFlagN <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_RSTINS_POS];
      end else if (events.resetInstruction) begin
         resetInstructionFlagN <= 1'b0;
      end else if (flagWrite) begin
         resetInstructionFlagN <= wrData[rcflag_pkg::BIT_RSTINS_POS];
      end
   end

   // R07: power-on clears, firmware sets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powerOnResetFlagN <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_POR_POS];
      end else if (flagWrite) begin
         powerOnResetFlagN <= wrData[rcflag_pkg::BIT_POR_POS];
      end
   end

   // R08: brown-out clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brownoutResetFlagN <= rcflag_pkg::FLAGS_POR_VAL[rcflag_pkg::BIT_BOR_POS];
      end else if (events.brownoutReset) begin
         brownoutResetFlagN <= 1'b0;
      end else if (flagWrite) begin
         brownoutResetFlagN <= wrData[rcflag_pkg::BIT_BOR_POS];
      end
   end

   // Register image from the flag flops
   always_comb begin
      flags = 8'h00;
      flags[rcflag_pkg::BIT_STACK_OVERFLOW_FLAG_POS] = stackOverflowFlag;
      flags[rcflag_pkg::BIT_STACK_UNDERFLOW_FLAG_POS] = stackUnderflowFlag;
      flags[rcflag_pkg::BIT_WDWV_POS] = watchdogWindowViolationFlag;
      flags[rcflag_pkg::BIT_WDTO_POS] = watchdogTimeoutResetFlagN;
      flags[rcflag_pkg::BIT_EXTPIN_POS] = externalResetPinFlagN;
      flags[rcflag_pkg::BIT_RSTINS_POS] = resetInstructionFlagN;
      flags[rcflag_pkg::BIT_POR_POS] = powerOnResetFlagN;
      flags[rcflag_pkg::BIT_BOR_POS] = brownoutResetFlagN;
   end

   // Read data stand one cycle, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 8'h00;
      end else if (flagRead) begin
         rdData <= flags;
      end else begin
         rdData <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/rcflag_sync.sv
// Two-flop synchroniser for the external reset pin indication
`timescale 1ns/1ps
`default_nettype none
module rcflag_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous level in, synchronous level out
   input wire logic asyncIn,
   output logic syncOut
);
   logic stage1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule
`default_nettype wire
